/* core/atv_regs.sv */
// Audio framing, stereo line checking and port-pair delay/skew register block.
`timescale 1ns/1ns
module atv_regs (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire atv_pkg::atv_bus_t bus,
  output logic [7:0]             rdData,
  output logic                   irq,
  input  wire logic              tdmBitEn,
  output atv_pkg::atv_tdm_t      tdmTx,
  input  wire logic              tdmRxFs,
  output logic                   tdmRxWordStart,
  input  wire logic              pixEn,
  input  wire logic              lineEnd,
  input  wire logic              timingFault,
  input  wire atv_pkg::atv_pix_t dsiPort0,
  input  wire atv_pkg::atv_pix_t dsiPort1,
  input  wire logic              dsiActive0,
  input  wire logic              dsiActive1,
  output atv_pkg::atv_pix_t      mergedPix
);
  import atv_pkg::*;

  atv_state_t st_ff;
  atv_state_t nxt_st;

  atv_pix_t   p0Dly;
  atv_pix_t   p1Dly;
  logic       stereoOn;
  logic       limitHit;
  logic       setOvf;
  logic       setFlt;
  logic       setMis;
  logic [2:0] setFlags;
  logic       readSts;
  logic       dualOk;
  logic       rxAct;
  logic [7:0] txNextCnt;

  atv_pix_delay u_dly0 (
    .clock    (clock),
    .rst      (rst),
    .delaySel (st_ff.port0InputDelay),
    .inPix    (dsiPort0),
    .outPix   (p0Dly)
  );

  atv_pix_delay u_dly1 (
    .clock    (clock),
    .rst      (rst),
    .delaySel (st_ff.port1InputDelay),
    .inPix    (dsiPort1),
    .outPix   (p1Dly)
  );

  // Sync is active for the selected width; frame is 8 slots of 32 bits.
  function automatic logic syncActive(input logic [1:0] widthSel,
                                      input logic [7:0] cnt);
    if (widthSel[1]) begin
      syncActive = (cnt == 8'h00);
    end else if (widthSel[0]) begin
      syncActive = (cnt < TDM_SLOT_BITS);
    end else begin
      syncActive = (cnt < TDM_HALF_FRAME);
    end
  endfunction

  function automatic logic [7:0] readMux(input atv_state_t s,
                                         input logic [7:0] a,
                                         input logic       ok);
    case (a)
      OFF_AUDIO:   readMux = {4'h0, s.syncPolaritySel, s.dataDelaySel,
                              s.syncPulseWidthSel};
      OFF_STS:     readMux = {5'h00, s.errFlags};
      OFF_SKEW:    readMux = {s.port1InputDelay, s.port0InputDelay, ok,
                              s.skewSign, s.skewMagnitude};
      OFF_MODE:    readMux = {s.sideBySideStereoEn, s.twoPortSideBySideEn,
                              4'h0, s.altLineEn, s.altPixelEn};
      OFF_HALF_LO: readMux = s.imageHalfLineLength[7:0];
      OFF_HALF_HI: readMux = {3'h0, s.imageHalfLineLength[12:8]};
      OFF_IRQ_STS: readMux = {5'h00, s.irqSts};
      OFF_IRQ_MSK: readMux = {5'h00, s.irqMsk};
      default:     readMux = 8'h00;
    endcase
  endfunction

  assign stereoOn = st_ff.altLineEn | st_ff.sideBySideStereoEn |
                    st_ff.altPixelEn;
  // Alternate-line buffering is half as deep, so its limit wins when set.
  assign limitHit = st_ff.altLineEn ? (st_ff.lineCnt >= OVF_ALTLINE) :
                    ((st_ff.sideBySideStereoEn | st_ff.altPixelEn) &&
                     (st_ff.lineCnt >= OVF_WIDE));
  assign setOvf = lineEnd && limitHit;
  assign setFlt = timingFault && stereoOn;
  assign setMis = lineEnd &&
                  ((st_ff.altLineEn && st_ff.oddLine &&
                    (st_ff.lineCnt != st_ff.prevLen)) ||
                   (st_ff.sideBySideStereoEn && !st_ff.altLineEn &&
                    (st_ff.lineCnt != {st_ff.imageHalfLineLength, 1'b0})));
  assign setFlags = {setOvf, setFlt, setMis};
  assign readSts = bus.rd && (bus.addr == OFF_STS);
  assign dualOk = dsiActive0 && dsiActive1 && st_ff.skInRange;
  assign rxAct = tdmRxFs ^ st_ff.syncPolaritySel;
  assign txNextCnt = st_ff.txCnt + 8'h01;

  always_comb begin
    nxt_st = st_ff;

    // Register writes; reserved bits are simply not stored.
    if (bus.wr) begin
      unique case (bus.addr)
        OFF_AUDIO: begin
          nxt_st.syncPolaritySel   = bus.wdata[AUD_POL_BIT];
          nxt_st.dataDelaySel      = bus.wdata[AUD_DLY_BIT];
          nxt_st.syncPulseWidthSel = bus.wdata[AUD_WID_LSB +: 2];
        end
        OFF_SKEW: begin
          nxt_st.port1InputDelay = bus.wdata[SKW_D1_LSB +: 2];
          nxt_st.port0InputDelay = bus.wdata[SKW_D0_LSB +: 2];
        end
        OFF_MODE: begin
          nxt_st.sideBySideStereoEn  = bus.wdata[MODE_SBS_BIT];
          nxt_st.twoPortSideBySideEn = bus.wdata[MODE_TWO_BIT];
          nxt_st.altLineEn           = bus.wdata[MODE_ALTL_BIT];
          nxt_st.altPixelEn          = bus.wdata[MODE_ALTP_BIT];
        end
        OFF_HALF_LO: nxt_st.imageHalfLineLength[7:0] = bus.wdata;
        OFF_HALF_HI: nxt_st.imageHalfLineLength[12:8] = bus.wdata[4:0];
        OFF_IRQ_MSK: nxt_st.irqMsk = bus.wdata[2:0];
        default: ;
      endcase
    end

    // Read data stand only in the cycle after the strobe.
    nxt_st.rdData = bus.rd ? readMux(st_ff, bus.addr, dualOk) : 8'h00;

    // A new error in the reading cycle survives the clear.
    nxt_st.errFlags = (readSts ? 3'h0 : st_ff.errFlags) | setFlags;

    // Interrupt status: write one to clear, hardware set wins.
    nxt_st.irqSts = ((bus.wr && (bus.addr == OFF_IRQ_STS)) ?
                     (st_ff.irqSts & ~bus.wdata[2:0]) : st_ff.irqSts) |
                    setFlags;

    // Generated frame: sync leads the first word by the data delay.
    if (tdmBitEn) begin
      nxt_st.txCnt = txNextCnt;
      nxt_st.tx.fs = syncActive(st_ff.syncPulseWidthSel, txNextCnt) ^
                     st_ff.syncPolaritySel;
      nxt_st.tx.wordStart = (txNextCnt == {7'h00, st_ff.dataDelaySel});
    end

    // Accepted frame: first word is at the active edge or one bit after.
    if (tdmBitEn) begin
      nxt_st.rxActPrev = rxAct;
      nxt_st.rxPend    = rxAct && !st_ff.rxActPrev;
      nxt_st.rxWord    = st_ff.dataDelaySel ? st_ff.rxPend :
                         (rxAct && !st_ff.rxActPrev);
    end

    // Line length accounting; lineEnd follows the last pixel of a line.
    if (lineEnd) begin
      nxt_st.lineCnt = '0;
      if (st_ff.altLineEn) begin
        nxt_st.prevLen = st_ff.lineCnt;
        nxt_st.oddLine = !st_ff.oddLine;
      end else begin
        nxt_st.oddLine = 1'b0;
      end
    end else if (pixEn && (st_ff.lineCnt != LEN_SAT)) begin
      nxt_st.lineCnt = st_ff.lineCnt + 14'h0001;
    end

    // Skew measurement between raw line starts on the two ports.
    unique case (st_ff.skState)
      SK_IDLE: begin
        if (dsiPort0.lineStart && dsiPort1.lineStart) begin
          nxt_st.skewMagnitude = 2'h0;
          nxt_st.skewSign      = 1'b0;
          nxt_st.skInRange     = 1'b1;
        end else if (dsiPort0.lineStart) begin
          nxt_st.skState = SK_P0LEAD;
          nxt_st.skCnt   = 2'h1;
        end else if (dsiPort1.lineStart) begin
          nxt_st.skState = SK_P1LEAD;
          nxt_st.skCnt   = 2'h1;
        end
      end
      SK_P0LEAD, SK_P1LEAD: begin
        if ((st_ff.skState == SK_P0LEAD) ? dsiPort1.lineStart :
            dsiPort0.lineStart) begin
          nxt_st.skewMagnitude = st_ff.skCnt;
          nxt_st.skewSign      = (st_ff.skState == SK_P1LEAD);
          nxt_st.skInRange     = 1'b1;
          nxt_st.skState       = SK_IDLE;
        end else if (st_ff.skCnt == SKEW_MAX) begin
          // Beyond three clocks the skew cannot be represented.
          nxt_st.skInRange = 1'b0;
          nxt_st.skState   = SK_IDLE;
        end else begin
          nxt_st.skCnt = st_ff.skCnt + 2'h1;
        end
      end
      default: nxt_st.skState = SK_IDLE;
    endcase

    // Merge of the delayed ports into one registered pixel stream.
    if (st_ff.twoPortSideBySideEn) begin
      if (p0Dly.valid && p0Dly.lineStart) begin
        nxt_st.mergeCnt = 14'h0001;
        nxt_st.merged   = p0Dly;
      end else if (p0Dly.valid && (st_ff.mergeCnt <
                   {1'b0, st_ff.imageHalfLineLength})) begin
        nxt_st.mergeCnt = st_ff.mergeCnt + 14'h0001;
        nxt_st.merged   = p0Dly;
      end else if (p1Dly.valid) begin
        nxt_st.merged           = p1Dly;
        nxt_st.merged.lineStart = 1'b0;
      end else begin
        nxt_st.merged = '0;
      end
    end else begin
      nxt_st.merged = p0Dly;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff                   <= '0;
      st_ff.syncPolaritySel   <= AUDIO_RST[AUD_POL_BIT];
      st_ff.dataDelaySel      <= AUDIO_RST[AUD_DLY_BIT];
      st_ff.syncPulseWidthSel <= AUDIO_RST[AUD_WID_LSB +: 2];
      st_ff.skState           <= SK_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdData         = st_ff.rdData;
  assign irq            = |(st_ff.irqSts & st_ff.irqMsk);
  assign tdmTx          = st_ff.tx;
  assign tdmRxWordStart = st_ff.rxWord;
  assign mergedPix      = st_ff.merged;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence seqStsRead;
    bus.rd && (bus.addr == OFF_STS) && (setFlags == 3'h0);
  endsequence

  sequence seqP0LeadsByTwo;
    (st_ff.skState == SK_IDLE) && dsiPort0.lineStart && !dsiPort1.lineStart
    ##1 !dsiPort0.lineStart && !dsiPort1.lineStart
    ##1 dsiPort1.lineStart && !dsiPort0.lineStart;
  endsequence

  sequence seqP1LeadsByOne;
    (st_ff.skState == SK_IDLE) && dsiPort1.lineStart && !dsiPort0.lineStart
    ##1 dsiPort0.lineStart && !dsiPort1.lineStart;
  endsequence

  AST_AUDIO_RESET: assert property (disable iff (1'b0)
    rst ##1 !rst |-> st_ff.syncPolaritySel &&
                     (st_ff.syncPulseWidthSel == 2'h2) && !st_ff.dataDelaySel)
    else $error("audio framing reset value wrong");

  AST_WORD_AT_DELAY: assert property (
    tdmBitEn |=> (st_ff.tx.wordStart ==
                  (st_ff.txCnt == {7'h00, $past(st_ff.dataDelaySel)})))
    else $error("first word marker not at programmed data delay");

  AST_FS_ONE_BIT: assert property (
    st_ff.syncPulseWidthSel[1] && tdmBitEn ##1
    (st_ff.tx.fs != $past(st_ff.syncPolaritySel)) |-> (st_ff.txCnt == 8'h00))
    else $error("one-bit sync active outside bit zero");

  AST_RX_DELAYED: assert property (
    tdmBitEn && st_ff.dataDelaySel && rxAct && !st_ff.rxActPrev
    ##1 tdmBitEn |=> tdmRxWordStart)
    else $error("accepted frame word start not one bit after sync");

  AST_CLEAR_ON_READ: assert property (
    seqStsRead |=> (st_ff.errFlags == 3'h0) &&
                   (rdData == {5'h00, $past(st_ff.errFlags)}))
    else $error("status read did not return and clear the flags");

  AST_OVF_ALTLINE: assert property (
    lineEnd && st_ff.altLineEn && (st_ff.lineCnt >= OVF_ALTLINE)
    |=> st_ff.errFlags[STS_OVF_BIT] [*2] or (st_ff.errFlags[STS_OVF_BIT]
    ##1 $past(readSts)))
    else $error("alternate-line overflow not flagged");

  AST_OVF_WIDE: assert property (
    lineEnd && !st_ff.altLineEn && st_ff.altPixelEn &&
    (st_ff.lineCnt < OVF_WIDE) && !timingFault && !setMis
    && !readSts |=> (st_ff.errFlags == $past(st_ff.errFlags)))
    else $error("wide-mode overflow raised below its limit");

  AST_FAULT: assert property (
    timingFault && stereoOn |=> st_ff.errFlags[STS_FLT_BIT])
    else $error("timing fault not flagged");

  AST_SBS_MISMATCH: assert property (
    lineEnd && st_ff.sideBySideStereoEn && !st_ff.altLineEn &&
    (st_ff.lineCnt != {st_ff.imageHalfLineLength, 1'b0})
    |=> st_ff.errFlags[STS_MIS_BIT])
    else $error("side-by-side length mismatch not flagged");

  AST_SKEW_P0_LEADS: assert property (
    seqP0LeadsByTwo |=> (st_ff.skewMagnitude == 2'h2) && !st_ff.skewSign)
    else $error("port 0 lead of two clocks measured wrongly");

  AST_SKEW_P1_LEADS: assert property (
    seqP1LeadsByOne |=> (st_ff.skewMagnitude == 2'h1) && st_ff.skewSign)
    else $error("port 1 lead not reported as negative skew");

  AST_DUAL_NEEDS_BOTH: assert property (
    bus.rd && (bus.addr == OFF_SKEW) && !(dsiActive0 && dsiActive1)
    |=> !rdData[SKW_OK_BIT])
    else $error("dual status set with a port inactive");

  AST_PORT0_DELAY: assert property (
    (st_ff.port0InputDelay == 2'h3 && !st_ff.twoPortSideBySideEn)[*4]
    |=> (mergedPix == $past(dsiPort0, 4)))
    else $error("port 0 delay of three clocks not applied");

endmodule // atv_regs

/* core/atv_pkg.sv */
// Constants, field layouts and carrier types for the audio/stereo/port-pair registers.
// Operation
// - Sync polarity bit 3: 0 active-high sync, 1 active-low sync; resets to 1.
// - The active sync pulse marks the first sample word of the frame.
// - Polarity and data delay apply to both generated and accepted frames.
// - Data delay bit 2: 0 data at sync edge, 1 data one bit later.
// - Sync width bits 1-0, reset 2: 00 half frame, 01 one slot, 1x one bit.
// - Alternate-line mode flags overflow, bit 2, for lines of 4096 or more pixels.
// - Side-by-side or alternate-pixel modes flag overflow for 8192 or more pixels.
// - A stereo timing fault sets the line timing fault flag, bit 1.
// - All three stereo error flags are sticky and clear when status is read.
// - Alternate-line mode flags mismatch, bit 0, when odd and even lengths differ.
// - Side-by-side mode flags mismatch when length is not twice the half length; not checked while alternate-line mode is set.
// - Port 1 delay, bits 7-6, delays second port video by 0 to 3 clocks.
// - Port 0 delay, bits 5-4, delays first port video by 0 to 3 clocks.
// - Dual status bit 3 is set only with both ports active and skew measurable.
// - Skew sign bit 2 reads 0 when port 0 leads or ties, 1 otherwise.
// - Skew magnitude bits 1-0 report the measured port skew in pixel clocks.
// - Side-by-side stereo enable selects the side-by-side checking mode.
// - Two-port side-by-side takes left half from port 0, right from port 1.
package atv_pkg;

  localparam int PIX_W = 24;
  localparam int LEN_W = 14;

  localparam logic [7:0] OFF_AUDIO   = 8'h57;
  localparam logic [7:0] OFF_STS     = 8'h58;
  localparam logic [7:0] OFF_SKEW    = 8'h59;
  localparam logic [7:0] OFF_MODE    = 8'h60;
  localparam logic [7:0] OFF_HALF_LO = 8'h61;
  localparam logic [7:0] OFF_HALF_HI = 8'h62;
  localparam logic [7:0] OFF_IRQ_STS = 8'h63;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h64;

  localparam int AUD_POL_BIT   = 3;
  localparam int AUD_DLY_BIT   = 2;
  localparam int AUD_WID_LSB   = 0;
  localparam int STS_OVF_BIT   = 2;
  localparam int STS_FLT_BIT   = 1;
  localparam int STS_MIS_BIT   = 0;
  localparam int SKW_D1_LSB    = 6;
  localparam int SKW_D0_LSB    = 4;
  localparam int SKW_OK_BIT    = 3;
  localparam int SKW_NEG_BIT   = 2;
  localparam int SKW_MAG_LSB   = 0;
  localparam int MODE_SBS_BIT  = 7;
  localparam int MODE_TWO_BIT  = 6;
  localparam int MODE_ALTL_BIT = 1;
  localparam int MODE_ALTP_BIT = 0;

  localparam logic [3:0] AUDIO_RST = 4'hA;
  localparam logic [LEN_W-1:0] OVF_ALTLINE = 14'h1000;
  localparam logic [LEN_W-1:0] OVF_WIDE    = 14'h2000;
  localparam logic [LEN_W-1:0] LEN_SAT     = 14'h3FFF;
  localparam logic [7:0] TDM_HALF_FRAME = 8'h80;
  localparam logic [7:0] TDM_SLOT_BITS  = 8'h20;
  localparam logic [1:0] SKEW_MAX = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } atv_bus_t;

  typedef struct packed {
    logic             valid;
    logic             lineStart;
    logic [PIX_W-1:0] data;
  } atv_pix_t;

  typedef struct packed {
    logic fs;
    logic wordStart;
  } atv_tdm_t;

  typedef enum logic [2:0] {
    SK_IDLE   = 3'b001,
    SK_P0LEAD = 3'b010,
    SK_P1LEAD = 3'b100
  } atv_skew_state_t;

  typedef struct packed {
    atv_pix_t [2:0] stage;
  } atv_dly_state_t;

  typedef struct packed {
    logic            syncPolaritySel;
    logic            dataDelaySel;
    logic [1:0]      syncPulseWidthSel;
    logic [2:0]      errFlags;
    logic [1:0]      port1InputDelay;
    logic [1:0]      port0InputDelay;
    logic            sideBySideStereoEn;
    logic            twoPortSideBySideEn;
    logic            altLineEn;
    logic            altPixelEn;
    logic [12:0]     imageHalfLineLength;
    logic [2:0]      irqSts;
    logic [2:0]      irqMsk;
    logic [7:0]      rdData;
    logic [7:0]      txCnt;
    atv_tdm_t        tx;
    logic            rxActPrev;
    logic            rxPend;
    logic            rxWord;
    logic [LEN_W-1:0] lineCnt;
    logic [LEN_W-1:0] prevLen;
    logic            oddLine;
    atv_skew_state_t skState;
    logic [1:0]      skCnt;
    logic [1:0]      skewMagnitude;
    logic            skewSign;
    logic            skInRange;
    logic [LEN_W-1:0] mergeCnt;
    atv_pix_t        merged;
  } atv_state_t;

endpackage

/* core/atv_pix_delay.sv */
// Programmable 0..3 pixel-clock delay for one video port.
`timescale 1ns/1ns
module atv_pix_delay (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [1:0]        delaySel,
  input  wire atv_pkg::atv_pix_t inPix,
  output atv_pkg::atv_pix_t      outPix
);
  import atv_pkg::*;

  atv_dly_state_t st_ff;
  atv_dly_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage[0] = inPix;
    nxt_st.stage[1] = st_ff.stage[0];
    nxt_st.stage[2] = st_ff.stage[1];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // A zero setting passes the port straight through; the merge stage registers it.
  always_comb begin
    unique case (delaySel)
      2'h0: outPix = inPix;
      2'h1: outPix = st_ff.stage[0];
      2'h2: outPix = st_ff.stage[1];
      2'h3: outPix = st_ff.stage[2];
    endcase
  end

endmodule // atv_pix_delay

/* verification/atv_regs_tb_top.sv */
// Self-checking testbench for the audio, stereo and port-pair register block.
`timescale 1ns/1ns
module atv_regs_tb_top;
  import atv_pkg::*;

  localparam int CEIL = 60000;

  logic     clock;
  logic     rst;
  atv_bus_t bus;
  logic     [7:0] rdData;
  logic     irq;
  logic     tdmBitEn;
  atv_tdm_t tdmTx;
  logic     tdmRxFs;
  logic     tdmRxWordStart;
  logic     pixEn;
  logic     lineEnd;
  logic     timingFault;
  atv_pix_t p0;
  atv_pix_t p1;
  logic     act0;
  logic     act1;
  atv_pix_t mergedPix;
  int       nFail;
  int       nTests;
  int       cyc;
  logic     [7:0] v;

  atv_regs u_atv_regs (
    .clock          (clock),
    .rst            (rst),
    .bus            (bus),
    .rdData         (rdData),
    .irq            (irq),
    .tdmBitEn       (tdmBitEn),
    .tdmTx          (tdmTx),
    .tdmRxFs        (tdmRxFs),
    .tdmRxWordStart (tdmRxWordStart),
    .pixEn          (pixEn),
    .lineEnd        (lineEnd),
    .timingFault    (timingFault),
    .dsiPort0       (p0),
    .dsiPort1       (p1),
    .dsiActive0     (act0),
    .dsiActive1     (act1),
    .mergedPix      (mergedPix)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clock) begin
    cyc++;
    if (cyc == CEIL) begin
      nFail++;
      testDone();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic line(input int n);
    repeat (n) begin
      @(posedge clock);
      pixEn <= 1'b1;
    end
    @(posedge clock);
    pixEn   <= 1'b0;
    lineEnd <= 1'b1;
    @(posedge clock);
    lineEnd <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // Counts active sync bits and word starts over exactly one 256-bit frame.
  task automatic txFrame(input logic [3:0] cfg);
    int act;
    int ws;
    int actWs;
    act = 0;
    ws = 0;
    actWs = 0;
    wr(OFF_AUDIO, {4'h0, cfg});
    repeat (3) @(posedge clock);
    repeat (256) begin
      @(posedge clock);
      #1;
      if ((tdmTx.fs ^ cfg[3]) === 1'b1) act++;
      if (tdmTx.wordStart === 1'b1) begin
        ws++;
        actWs = int'(tdmTx.fs ^ cfg[3]);
      end
    end
    check(act, cfg[1] ? 1 : (cfg[0] ? 32 : 128));
    check(ws, 1);
    check(actWs, (cfg[2] && cfg[1]) ? 0 : 1);
  endtask

  task automatic rxLat(input logic [3:0] cfg);
    int got;
    got = 0;
    wr(OFF_AUDIO, {4'h0, cfg});
    tdmRxFs <= cfg[3];
    repeat (4) @(posedge clock);
    tdmRxFs <= ~cfg[3];
    for (int k = 1; k <= 4; k++) begin
      @(posedge clock);
      #1;
      if (got == 0 && tdmRxWordStart === 1'b1) got = k;
    end
    check(got, cfg[2] ? 2 : 1);
  endtask

  task automatic skew(input bit p1First, input int k, input logic [7:0] m,
                      input logic [7:0] exp);
    @(posedge clock);
    p0.lineStart <= (k == 0) || !p1First;
    p1.lineStart <= (k == 0) || p1First;
    // Each edge drives each start once, so the lagging port's pulse
    // never collides with the clearing of the leading one.
    for (int i = 1; i <= k; i++) begin
      @(posedge clock);
      p0.lineStart <= p1First && (i == k);
      p1.lineStart <= !p1First && (i == k);
    end
    @(posedge clock);
    p0.lineStart <= 1'b0;
    p1.lineStart <= 1'b0;
    repeat (2) @(posedge clock);
    rd(OFF_SKEW, v);
    check(v & m, exp);
  endtask

  // Sends one pixel and checks the cycles until it leaves the merge.
  task automatic lat(input bit port, input bit ls, input logic [23:0] d,
                     input int exp);
    int got;
    got = 0;
    @(posedge clock);
    if (port) p1 <= '{valid: 1'b1, lineStart: ls, data: d};
    else p0 <= '{valid: 1'b1, lineStart: ls, data: d};
    for (int k = 1; k <= 6; k++) begin
      @(posedge clock);
      if (k == 1) begin
        p0 <= '{valid: 1'b0, lineStart: 1'b0, data: ~d};
        p1 <= '{valid: 1'b0, lineStart: 1'b0, data: d ^ 24'h00FF00};
      end
      #1;
      if (got == 0 && mergedPix.valid === 1'b1 && mergedPix.data === d) got = k;
    end
    check(got, exp);
  endtask

  initial begin
    rst = 1'b1;
    bus = '0;
    tdmBitEn = 1'b0;
    tdmRxFs = 1'b0;
    pixEn = 1'b0;
    lineEnd = 1'b0;
    timingFault = 1'b0;
    p0 = '0;
    p1 = '0;
    act0 = 1'b0;
    act1 = 1'b0;
    nFail = 0;
    nTests = 0;
    cyc = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    tdmBitEn <= 1'b1;
    @(posedge clock);

    rd(OFF_AUDIO, v);
    check(v, 8'h0A);
    rd(OFF_STS, v);
    check(v, 8'h00);
    rd(OFF_SKEW, v);
    check(v, 8'h00);
    rd(8'h70, v);
    check(v, 8'h00);
    wr(OFF_AUDIO, 8'hFF);
    rd(OFF_AUDIO, v);
    check(v, 8'h0F);
    wr(OFF_STS, 8'hFF);
    rd(OFF_STS, v);
    check(v, 8'h00);
    wr(OFF_SKEW, 8'hFF);
    rd(OFF_SKEW, v);
    check(v, 8'hF0);
    $display("test registers done");

    for (int c = 0; c < 16; c++) txFrame(4'(c));
    for (int c = 0; c < 16; c += 4) rxLat(4'(c));
    $display("test audio framing done");

    // With no stereo mode set a fault pulse must leave the status clear.
    @(posedge clock) timingFault <= 1'b1;
    @(posedge clock) timingFault <= 1'b0;
    rd(OFF_STS, v);
    check(v, 8'h00);
    wr(OFF_MODE, 8'h80);
    wr(OFF_HALF_LO, 8'h04);
    wr(OFF_HALF_HI, 8'h00);
    line(10);
    rd(OFF_STS, v);
    check(v, 8'h01);
    rd(OFF_STS, v);
    check(v, 8'h00);
    line(8);
    rd(OFF_STS, v);
    check(v, 8'h00);
    @(posedge clock) timingFault <= 1'b1;
    @(posedge clock) timingFault <= 1'b0;
    repeat (3) @(posedge clock);
    rd(OFF_STS, v);
    check(v, 8'h02);
    rd(OFF_IRQ_STS, v);
    check(v, 8'h03);
    check(irq, 1'b0);
    wr(OFF_IRQ_MSK, 8'h02);
    repeat (2) @(posedge clock);
    #1;
    check(irq, 1'b1);
    wr(OFF_IRQ_STS, 8'h02);
    repeat (2) @(posedge clock);
    #1;
    check(irq, 1'b0);
    rd(OFF_IRQ_STS, v);
    check(v, 8'h01);
    $display("test side by side done");

    wr(OFF_MODE, 8'h02);
    line(5);
    line(6);
    rd(OFF_STS, v);
    check(v & 8'h01, 8'h01);
    line(4095);
    rd(OFF_STS, v);
    check(v & 8'h04, 8'h00);
    line(4096);
    rd(OFF_STS, v);
    check(v & 8'h04, 8'h04);
    wr(OFF_MODE, 8'h01);
    line(8191);
    rd(OFF_STS, v);
    check(v & 8'h04, 8'h00);
    line(8192);
    rd(OFF_STS, v);
    check(v & 8'h04, 8'h04);
    $display("test line buffer done");

    wr(OFF_MODE, 8'h00);
    act0 <= 1'b1;
    act1 <= 1'b1;
    skew(1'b0, 0, 8'h0F, 8'h08);
    for (int k = 1; k <= 3; k++) begin
      skew(1'b0, k, 8'h0F, 8'h08 | 8'(k));
      skew(1'b1, k, 8'h0F, 8'h0C | 8'(k));
    end
    skew(1'b0, 4, 8'h08, 8'h00);
    act1 <= 1'b0;
    skew(1'b0, 0, 8'h08, 8'h00);
    $display("test skew done");

    wr(OFF_MODE, 8'h40);
    wr(OFF_HALF_LO, 8'h02);
    for (int d = 0; d < 4; d++) begin
      wr(OFF_SKEW, 8'(d << 4));
      lat(1'b0, 1'b1, 24'hA00000 | 24'(d), d + 1);
      lat(1'b0, 1'b0, 24'hA10000 | 24'(d), d + 1);
      wr(OFF_SKEW, 8'(d << 6));
      lat(1'b1, 1'b0, 24'hB00000 | 24'(d), d + 1);
    end
    // Outside two-port mode the merge passes the delayed port 0 stream.
    wr(OFF_MODE, 8'h00);
    wr(OFF_SKEW, 8'h30);
    lat(1'b0, 1'b0, 24'hC00003, 4);
    $display("test port delay done");
    testDone();
  end
endmodule // atv_regs_tb_top
